// [pkg/atf_pkg.sv]
// Constants and carrier types of the AT task file host port
package atf_pkg;

	// ==========================================================
	// Host offsets
	localparam logic [3:0] ATF_OFF_ERROR = 4'h1;
	localparam logic [3:0] ATF_OFF_SECT_CNT = 4'h2;
	localparam logic [3:0] ATF_OFF_SECT_NUM = 4'h3;
	localparam logic [3:0] ATF_OFF_CYL_LO = 4'h4;
	localparam logic [3:0] ATF_OFF_CYL_HI = 4'h5;
	localparam logic [3:0] ATF_OFF_DRV_HEAD = 4'h6;
	localparam logic [3:0] ATF_OFF_STAT_CMD = 4'h7;
	localparam logic [3:0] ATF_OFF_ALT_FDC = 4'hE;

	// ==========================================================
	// Field positions
	localparam int ATF_DH_ECC_SEL = 7;
	localparam int ATF_DH_SECTOR_SIZE_SEL = 5;
	localparam int ATF_DH_DRIVE_NUMBER_BIT = 4;
	localparam int ATF_ST_BUSY = 7;
	localparam int ATF_ST_INDEX = 1;
	localparam int ATF_FDC_HEAD3_SELECT_ENABLE = 3;
	localparam int ATF_FDC_SOFT_RESET = 2;
	localparam int ATF_FDC_INTERRUPT_INHIBIT_N = 1;

	// ==========================================================
	// Reset values
	localparam logic [7:0] ATF_REG_RST = 8'h00;
	localparam logic ATF_BUSY_RST = 1'b1;
	localparam logic [7:0] ATF_UNMAPPED_READ = 8'h00;

	// ==========================================================
	// Timing: least soft reset hold time, owed by the host
	localparam int ATF_CLK_PERIOD_PS = 5000;
	localparam int ATF_SOFT_RESET_MIN_PS = 5000000;
	localparam int ATF_SOFT_RESET_MIN_CYC =
		(ATF_SOFT_RESET_MIN_PS + ATF_CLK_PERIOD_PS - 1) / ATF_CLK_PERIOD_PS;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic drive_ready_pin;
		logic write_fault;
		logic seek_done;
		logic data_corrected;
		logic error;
	} atf_drv_stat_t;

	typedef struct packed {
		logic we;
		logic drive;
		atf_drv_stat_t value;
	} atf_stat_wr_t;

	typedef struct packed {
		logic [7:0] sect_cnt;
		logic [7:0] sect_num;
		logic [7:0] cyl_lo;
		logic [7:0] cyl_hi;
		logic [7:0] drive_head_select;
	} atf_task_t;

	typedef struct packed {
		logic ecc_sel;
		logic sector_size_sel;
		logic drive_number_bit;
		logic [3:0] head;
		logic [10:0] cylinder;
	} atf_target_t;

endpackage

// [rtl/atf_host_port.sv]
// AT task file host port: host registers, status mux and micro hand-off
// How it works
// RQ1: Sector number register, read/write, offset 3
// RQ2: Cylinder is low byte plus high bits 2:0
// RQ3: Cylinder high stores all eight bits
// RQ4: Drive/head bit 7 selects ECC or CRC
// RQ5: Drive/head bit 5 selects 256/512 sectors
// RQ6: Drive/head bit 4 picks status drive
// RQ7: Head number from drive/head bits 3:0
// RQ8: Status read-only; offset 7 read clears interrupt
// RQ9: Busy set by command or reset, micro clears
// RQ10: Micro writes ready and fault status bits
// RQ11: Micro writes seek, corrected, error bits
// RQ12: Data request bit follows buffer manager
// RQ13: Status bit 1 follows index pin
// RQ14: Command write latches, busies, interrupts micro
// RQ15: Offset E read returns same status
// RQ16: Fixed disk register keeps all eight bits
// RQ17: Bit 3 picks head select 3 or REDUCED_WRITE_CURRENT
// RQ18: Bit 2 holds reset, drives reset output
// RQ19: Host holds reset bit five microseconds
// RQ20: Inhibit tristates pin, blocks new interrupts
// RQ21: Master reset clears pending; power reset enables
// RQ22: Task registers locked while busy
// RQ23: Sector done bumps number, drops count
// RQ24: Chip select plus address decode offsets
module atf_host_port (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic MASTER_RESET,
	input wire logic HOST_CS_N,
	input wire logic HOST_RD,
	input wire logic HOST_WR,
	input wire logic [3:0] HOST_ADDR,
	input wire logic [7:0] HOST_WDATA,
	output logic [7:0] HOST_RDATA,
	output logic HOST_RVALID,
	output logic HOST_INTERRUPT,
	output logic HOST_INTERRUPT_OE,
	input wire atf_pkg::atf_stat_wr_t MC_STAT_WR,
	input wire logic MC_BUSY_CLR,
	input wire logic MC_HOST_IRQ,
	input wire logic MC_INT_ACK,
	input wire logic MC_RESET_DISABLE,
	output logic MICRO_INTERRUPT,
	output logic [7:0] MC_COMMAND,
	output logic [7:0] MC_FIXED_DISK,
	output atf_pkg::atf_task_t TASK_FILE,
	output atf_pkg::atf_target_t TARGET,
	input wire logic DATA_REQUEST_FLAG,
	input wire logic INDEX_FLAG,
	input wire logic SECTOR_DONE,
	output logic HEAD3_SELECT_ENABLE,
	output logic RESET_OUT
);

	// ==========================================================
	// State
	typedef struct packed {
		atf_pkg::atf_task_t task_file;
		atf_pkg::atf_drv_stat_t [1:0] drv_stat;
		logic [7:0] command;
		logic [7:0] fixed_disk;
		logic controller_busy;
		logic irq_pending;
		logic irq_oe;
		logic micro_interrupt;
		logic [7:0] rdata;
		logic rvalid;
		logic reset_out;
	} atf_state_t;

	atf_state_t s;
	atf_state_t next_s;
	logic host_rd;
	logic host_wr;
	logic in_reset;
	logic [7:0] status_byte;
	atf_pkg::atf_drv_stat_t sel_stat;

	// Read and write strobes qualified by chip select
	assign host_rd = HOST_RD & ~HOST_CS_N; // RQ24
	assign host_wr = HOST_WR & ~HOST_CS_N; // RQ24
	assign in_reset = s.fixed_disk[atf_pkg::ATF_FDC_SOFT_RESET] | MASTER_RESET;

	// Status of the drive named by the drive/head register
	assign sel_stat =
		s.drv_stat[s.task_file.drive_head_select[atf_pkg::ATF_DH_DRIVE_NUMBER_BIT]]; // RQ6
	assign status_byte = {s.controller_busy, // RQ9
		sel_stat.drive_ready_pin, sel_stat.write_fault, // RQ10
		sel_stat.seek_done, // RQ11
		DATA_REQUEST_FLAG, // RQ12
		sel_stat.data_corrected, // RQ11
		INDEX_FLAG, // RQ13
		sel_stat.error}; // RQ11

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;
		next_s.rvalid = 1'b0;
		// Micro side updates of the per-drive status
		if (MC_STAT_WR.we) begin
			next_s.drv_stat[MC_STAT_WR.drive] = MC_STAT_WR.value; // RQ10 RQ11
		end
		if (MC_BUSY_CLR) begin
			next_s.controller_busy = 1'b0; // RQ9
		end
		if (MC_INT_ACK) begin
			next_s.micro_interrupt = 1'b0;
		end
		// Sector stepping; a host write in the same cycle wins below while not busy
		if (SECTOR_DONE) begin
			next_s.task_file.sect_num = s.task_file.sect_num + 8'h01; // RQ23
			next_s.task_file.sect_cnt = s.task_file.sect_cnt - 8'h01; // RQ23
		end
		// Status read at offset 7 acknowledges the host interrupt
		if (host_rd && HOST_ADDR == atf_pkg::ATF_OFF_STAT_CMD) begin
			next_s.irq_pending = 1'b0; // RQ8
		end
		// Host writes; task file is locked while busy
		if (host_wr) begin
			case (HOST_ADDR)
				atf_pkg::ATF_OFF_SECT_CNT: begin
					if (!s.controller_busy) begin
						next_s.task_file.sect_cnt = HOST_WDATA; // RQ22
					end
				end
				atf_pkg::ATF_OFF_SECT_NUM: begin
					if (!s.controller_busy) begin
						next_s.task_file.sect_num = HOST_WDATA; // RQ1 RQ22
					end
				end
				atf_pkg::ATF_OFF_CYL_LO: begin
					if (!s.controller_busy) begin
						next_s.task_file.cyl_lo = HOST_WDATA; // RQ2 RQ22
					end
				end
				atf_pkg::ATF_OFF_CYL_HI: begin
					if (!s.controller_busy) begin
						next_s.task_file.cyl_hi = HOST_WDATA; // RQ3 RQ22
					end
				end
				atf_pkg::ATF_OFF_DRV_HEAD: begin
					if (!s.controller_busy) begin
						next_s.task_file.drive_head_select = HOST_WDATA; // RQ22
					end
				end
				atf_pkg::ATF_OFF_STAT_CMD: begin
					if (!s.controller_busy) begin
						next_s.command = HOST_WDATA; // RQ14
						next_s.controller_busy = 1'b1; // RQ9 RQ14
						next_s.micro_interrupt = 1'b1; // RQ14
						next_s.irq_pending = 1'b0; // RQ14
					end
				end
				atf_pkg::ATF_OFF_ALT_FDC: begin
					next_s.fixed_disk = HOST_WDATA; // RQ16
					// With reset disabled the micro is told instead
					if (HOST_WDATA[atf_pkg::ATF_FDC_SOFT_RESET] && MC_RESET_DISABLE
						&& !s.fixed_disk[atf_pkg::ATF_FDC_SOFT_RESET]) begin
						next_s.micro_interrupt = 1'b1; // RQ18
					end
				end
				default: begin
				end
			endcase
		end
		// Host reads, answered one cycle later
		if (host_rd) begin
			next_s.rvalid = 1'b1;
			case (HOST_ADDR)
				atf_pkg::ATF_OFF_SECT_CNT: begin
					next_s.rdata = s.task_file.sect_cnt;
				end
				atf_pkg::ATF_OFF_SECT_NUM: begin
					next_s.rdata = s.task_file.sect_num; // RQ1
				end
				atf_pkg::ATF_OFF_CYL_LO: begin
					next_s.rdata = s.task_file.cyl_lo;
				end
				atf_pkg::ATF_OFF_CYL_HI: begin
					next_s.rdata = s.task_file.cyl_hi; // RQ3
				end
				atf_pkg::ATF_OFF_DRV_HEAD: begin
					next_s.rdata = s.task_file.drive_head_select;
				end
				atf_pkg::ATF_OFF_STAT_CMD, atf_pkg::ATF_OFF_ALT_FDC: begin
					next_s.rdata = status_byte; // RQ8 RQ15
				end
				default: begin
					next_s.rdata = atf_pkg::ATF_UNMAPPED_READ;
				end
			endcase
			// Busy hides the task file behind the status byte
			if (s.controller_busy && HOST_ADDR >= atf_pkg::ATF_OFF_ERROR
				&& HOST_ADDR <= atf_pkg::ATF_OFF_STAT_CMD) begin
				next_s.rdata = status_byte; // RQ22
			end
		end
		// New interrupts only while not inhibited; set beats read clear
		if (MC_HOST_IRQ && !s.fixed_disk[atf_pkg::ATF_FDC_INTERRUPT_INHIBIT_N]) begin
			next_s.irq_pending = 1'b1; // RQ20
		end
		// Any reset keeps busy up and drops a pending interrupt
		if (in_reset) begin
			next_s.controller_busy = 1'b1; // RQ9 RQ18
			next_s.irq_pending = 1'b0; // RQ21
		end
		// Pin tristates while inhibited; pending state is kept
		next_s.irq_oe = ~next_s.fixed_disk[atf_pkg::ATF_FDC_INTERRUPT_INHIBIT_N]; // RQ20
		next_s.reset_out = next_s.fixed_disk[atf_pkg::ATF_FDC_SOFT_RESET]
			& ~MC_RESET_DISABLE; // RQ18
	end

	// ==========================================================
	// Registers; power reset enables interrupts and raises busy
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			s <= '0;
			s.fixed_disk <= atf_pkg::ATF_REG_RST; // RQ21
			s.controller_busy <= atf_pkg::ATF_BUSY_RST; // RQ9
			s.irq_oe <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign HOST_RDATA = s.rdata;
	assign HOST_RVALID = s.rvalid;
	assign HOST_INTERRUPT = s.irq_pending;
	assign HOST_INTERRUPT_OE = s.irq_oe;
	assign MICRO_INTERRUPT = s.micro_interrupt;
	assign MC_COMMAND = s.command;
	assign MC_FIXED_DISK = s.fixed_disk; // RQ16
	assign TASK_FILE = s.task_file;
	assign RESET_OUT = s.reset_out;
	// Shared drive line function select
	assign HEAD3_SELECT_ENABLE = s.fixed_disk[atf_pkg::ATF_FDC_HEAD3_SELECT_ENABLE]; // RQ17
	// Decoded target fields, one driver for the whole struct
	assign TARGET = {s.task_file.drive_head_select[atf_pkg::ATF_DH_ECC_SEL], // RQ4
		s.task_file.drive_head_select[atf_pkg::ATF_DH_SECTOR_SIZE_SEL], // RQ5
		s.task_file.drive_head_select[atf_pkg::ATF_DH_DRIVE_NUMBER_BIT], // RQ6
		s.task_file.drive_head_select[3:0], // RQ7
		s.task_file.cyl_hi[2:0], s.task_file.cyl_lo}; // RQ2

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESET_N);

	sequence s_cmd_write;
		host_wr && HOST_ADDR == atf_pkg::ATF_OFF_STAT_CMD && !s.controller_busy;
	endsequence

	sequence s_soft_reset_write;
		host_wr && HOST_ADDR == atf_pkg::ATF_OFF_ALT_FDC
			&& HOST_WDATA[atf_pkg::ATF_FDC_SOFT_RESET] && !MC_RESET_DISABLE;
	endsequence

	property p_status_read_clears;
		host_rd && HOST_ADDR == atf_pkg::ATF_OFF_STAT_CMD && !MC_HOST_IRQ
			|=> !HOST_INTERRUPT;
	endproperty
	a_status_read_clears: assert property (p_status_read_clears) // RQ8
		else $error("status read left interrupt pending");

	property p_cmd_write;
		s_cmd_write |=> MICRO_INTERRUPT && s.controller_busy
			&& MC_COMMAND == $past(HOST_WDATA);
	endproperty
	a_cmd_write: assert property (p_cmd_write) // RQ14
		else $error("command write not latched or signalled");

	property p_drive_status_select;
		host_rd && HOST_ADDR == atf_pkg::ATF_OFF_STAT_CMD
			|=> HOST_RVALID && HOST_RDATA[6] == $past(sel_stat.drive_ready_pin)
			&& HOST_RDATA[atf_pkg::ATF_ST_BUSY] == $past(s.controller_busy);
	endproperty
	a_drive_status_select: assert property (p_drive_status_select) // RQ6
		else $error("status read returned wrong drive");

	property p_index_live;
		host_rd && HOST_ADDR == atf_pkg::ATF_OFF_ALT_FDC
			|=> HOST_RDATA[atf_pkg::ATF_ST_INDEX] == $past(INDEX_FLAG);
	endproperty
	a_index_live: assert property (p_index_live) // RQ13
		else $error("index bit does not follow pin");

	property p_locked_while_busy;
		host_wr && HOST_ADDR == atf_pkg::ATF_OFF_SECT_NUM && s.controller_busy
			&& !SECTOR_DONE |=> $stable(s.task_file.sect_num);
	endproperty
	a_locked_while_busy: assert property (p_locked_while_busy) // RQ22
		else $error("task file written while busy");

	property p_inhibit_blocks;
		s.fixed_disk[atf_pkg::ATF_FDC_INTERRUPT_INHIBIT_N] && !HOST_INTERRUPT
			|=> !HOST_INTERRUPT;
	endproperty
	a_inhibit_blocks: assert property (p_inhibit_blocks) // RQ20
		else $error("interrupt raised while inhibited");

	property p_sector_step;
		SECTOR_DONE && !host_wr |=> s.task_file.sect_num == $past(s.task_file.sect_num)
			+ 8'h01 && s.task_file.sect_cnt == $past(s.task_file.sect_cnt) - 8'h01;
	endproperty
	a_sector_step: assert property (p_sector_step) // RQ23
		else $error("sector registers not stepped");

	property p_soft_reset;
		s_soft_reset_write ##1 !MC_RESET_DISABLE |-> RESET_OUT ##1 s.controller_busy;
	endproperty
	a_soft_reset: assert property (p_soft_reset) // RQ18
		else $error("soft reset did not assert reset output");

	property p_master_reset;
		MASTER_RESET && !(host_wr && HOST_ADDR == atf_pkg::ATF_OFF_ALT_FDC)
			|=> !HOST_INTERRUPT && s.controller_busy
			&& s.fixed_disk[atf_pkg::ATF_FDC_INTERRUPT_INHIBIT_N]
			== $past(s.fixed_disk[atf_pkg::ATF_FDC_INTERRUPT_INHIBIT_N]);
	endproperty
	a_master_reset: assert property (p_master_reset) // RQ21
		else $error("master reset handling wrong");

	// Busy reads of offsets 1 to 7 must show the status byte
	property p_busy_read_status;
		host_rd && s.controller_busy && HOST_ADDR >= atf_pkg::ATF_OFF_ERROR
			&& HOST_ADDR <= atf_pkg::ATF_OFF_STAT_CMD
			|=> HOST_RDATA[atf_pkg::ATF_ST_BUSY] && HOST_RDATA == $past(status_byte);
	endproperty
	a_busy_read_status: assert property (p_busy_read_status) // RQ22
		else $error("busy read did not return status");

	// Reset disabled by the micro: no reset output, micro told
	property p_reset_masked;
		host_wr && HOST_ADDR == atf_pkg::ATF_OFF_ALT_FDC
			&& HOST_WDATA[atf_pkg::ATF_FDC_SOFT_RESET] && MC_RESET_DISABLE
			&& !s.fixed_disk[atf_pkg::ATF_FDC_SOFT_RESET] |=> MICRO_INTERRUPT && !RESET_OUT;
	endproperty
	a_reset_masked: assert property (p_reset_masked) // RQ18
		else $error("masked reset not passed to micro");

	property p_fixed_disk_store;
		host_wr && HOST_ADDR == atf_pkg::ATF_OFF_ALT_FDC
			|=> MC_FIXED_DISK == $past(HOST_WDATA);
	endproperty
	a_fixed_disk_store: assert property (p_fixed_disk_store) // RQ16
		else $error("fixed disk byte not stored");

	// Pin drive follows the inhibit bit as written
	property p_inhibit_oe;
		host_wr && HOST_ADDR == atf_pkg::ATF_OFF_ALT_FDC
			|=> HOST_INTERRUPT_OE != $past(HOST_WDATA[atf_pkg::ATF_FDC_INTERRUPT_INHIBIT_N]);
	endproperty
	a_inhibit_oe: assert property (p_inhibit_oe) // RQ20
		else $error("interrupt pin enable wrong");

	property p_cyl_high_store;
		host_wr && HOST_ADDR == atf_pkg::ATF_OFF_CYL_HI && !s.controller_busy
			|=> TASK_FILE.cyl_hi == $past(HOST_WDATA);
	endproperty
	a_cyl_high_store: assert property (p_cyl_high_store) // RQ3
		else $error("cylinder high byte not stored");

	property p_busy_in_reset;
		in_reset |=> s.controller_busy;
	endproperty
	a_busy_in_reset: assert property (p_busy_in_reset) // RQ9
		else $error("busy low during reset");

	// Micro status write lands in the named drive; the other drive is not checked
	property p_micro_stat_write;
		MC_STAT_WR.we |=> s.drv_stat[$past(MC_STAT_WR.drive)] == $past(MC_STAT_WR.value);
	endproperty
	a_micro_stat_write: assert property (p_micro_stat_write) // RQ10
		else $error("drive status write lost");

endmodule

// [dv/atf_host_model.sv]
// Host processor model: byte wide I/O cycles on the task file port
module atf_host_model (
	input wire logic clk_sys,
	output logic cs_n,
	output logic rd,
	output logic wr,
	output logic [3:0] addr,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Idle bus
	initial begin
		cs_n = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		addr = 4'h0;
		wdata = 8'h5A;
	end
	// Write cycle; released data shows its inverse, never a stale copy
	task automatic put(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		cs_n <= 1'b0;
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		cs_n <= 1'b1;
		wr <= 1'b0;
		wdata <= ~d;
		#1;
	endtask
	// Read cycle; a missing answer comes back unknown
	task automatic get(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		cs_n <= 1'b0;
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		cs_n <= 1'b1;
		rd <= 1'b0;
		#1;
		d = rvalid ? rdata : 8'hXX;
	endtask
endmodule

// [dv/at_task_file_host_port_test.sv]
// Self-checking bench of the AT task file host port
module at_task_file_host_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, reset_n, mrst, cs_n, rd, wr, irq, oe, mint, hs3, rout, rvalid;
	logic rst_dis, data_request_flag, idx;
	logic [3:0] addr, mp;
	logic [7:0] wdata, rdata, cmd, fdc, v;
	logic [7:0] dat [4] = '{8'hFF, 8'hA5, 8'hFE, 8'hB9};
	atf_pkg::atf_stat_wr_t sw;
	atf_pkg::atf_task_t tf;
	atf_pkg::atf_target_t tg;
	int n_errors, cmp_count;

	// ==========================================================
	// Clock, 5 ns period
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	atf_host_port u_dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .MASTER_RESET(mrst),
		.HOST_CS_N(cs_n), .HOST_RD(rd), .HOST_WR(wr), .HOST_ADDR(addr),
		.HOST_WDATA(wdata), .HOST_RDATA(rdata), .HOST_RVALID(rvalid),
		.HOST_INTERRUPT(irq), .HOST_INTERRUPT_OE(oe), .MC_STAT_WR(sw),
		.MC_BUSY_CLR(mp[0]), .MC_HOST_IRQ(mp[1]), .MC_INT_ACK(mp[2]),
		.MC_RESET_DISABLE(rst_dis), .MICRO_INTERRUPT(mint), .MC_COMMAND(cmd),
		.MC_FIXED_DISK(fdc), .TASK_FILE(tf), .TARGET(tg), .DATA_REQUEST_FLAG(data_request_flag),
		.INDEX_FLAG(idx), .SECTOR_DONE(mp[3]), .HEAD3_SELECT_ENABLE(hs3),
		.RESET_OUT(rout));

	atf_host_model u_host (.clk_sys(clk_sys), .cs_n(cs_n), .rd(rd), .wr(wr),
		.addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid));

	// ==========================================================
	// Checking and micro-side pulses
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
		u_host.get(a, v);
		chk(n, 16'(e), 16'(v));
	endtask
	// One-cycle pulse on busy clear, host irq, ack, sector done
	task automatic pulse(input logic [3:0] m);
		@(posedge clk_sys);
		mp <= m;
		@(posedge clk_sys);
		mp <= 4'h0;
		#1;
	endtask
	task automatic stop_test();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		stop_test();
	end

	// ==========================================================
	// Main sequence
	initial begin
		n_errors = 0;
		cmp_count = 0;
		reset_n = 1'b0;
		{mrst, rst_dis, data_request_flag, mp} = '0;
		idx = 1'b1;
		sw = '0;
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		rchk("busy read", 4'h3, 8'h82);
		rchk("busy read", 4'h1, 8'h82);
		pulse(4'h1);
		rchk("unmapped", 4'h1, 8'h00);
		for (int i = 0; i < 4; i++) begin
			u_host.put(4'(i + 3), dat[i]);
		end
		for (int i = 0; i < 4; i++) begin
			rchk("task reg", 4'(i + 3), dat[i]);
		end
		// Per-drive status, then read through both offsets
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_sys);
			sw <= '{1'b1, i[0], i ? 5'h0A : 5'h15};
			@(posedge clk_sys);
			sw.we <= 1'b0;
		end
		data_request_flag <= 1'b1;
		idx <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			u_host.put(4'h6, {3'b101, i[0], 4'h9});
			rchk("status", 4'h7, i ? 8'h2C : 8'h59);
			rchk("alt status", 4'hE, i ? 8'h2C : 8'h59);
		end
		chk("cylinder", 16'h06A5, 16'(tg.cylinder));
		chk("target", 16'h0079, 16'({tg.ecc_sel, tg.sector_size_sel,
			tg.drive_number_bit, tg.head}));
		// Pending irq survives alternate read and inhibit
		pulse(4'h2);
		rchk("alt status", 4'hE, 8'h2C);
		u_host.put(4'hE, 8'h0A);
		chk("fixed disk", 16'h0A, 16'(fdc));
		chk("hs3 oe irq", 16'h5, 16'({hs3, oe, irq}));
		rchk("status", 4'h7, 8'h2C);
		pulse(4'h2);
		chk("blocked irq", 16'h0, 16'(irq));
		u_host.put(4'hE, 8'h00);
		chk("hs3 oe irq", 16'h2, 16'({hs3, oe, irq}));
		// Command write, then locked task file
		pulse(4'h2);
		u_host.put(4'h7, 8'hEC);
		chk("command", 16'h1EC, 16'({irq, mint, cmd}));
		u_host.put(4'h3, 8'h11);
		rchk("locked read", 4'h3, 8'hAC);
		pulse(4'h4);
		chk("micro irq", 16'h0, 16'(mint));
		pulse(4'h1);
		rchk("sector number", 4'h3, 8'hFF);
		pulse(4'h8);
		chk("count number", 16'hFF00, 16'({tf.sect_cnt, tf.sect_num}));
		// Soft reset, enabled then disabled by the micro
		u_host.put(4'hE, 8'h04);
		chk("reset out", 16'h1, 16'(rout));
		repeat (atf_pkg::ATF_SOFT_RESET_MIN_CYC) @(posedge clk_sys);
		u_host.get(4'hE, v);
		chk("busy in reset", 16'h80, 16'(v & 8'h80));
		u_host.put(4'hE, 8'h00);
		chk("reset out", 16'h0, 16'(rout));
		@(posedge clk_sys);
		rst_dis <= 1'b1;
		u_host.put(4'hE, 8'h04);
		chk("reset micro", 16'h1, 16'({rout, mint}));
		u_host.put(4'hE, 8'h00);
		// Master reset keeps inhibit, power reset clears it
		pulse(4'h2);
		u_host.put(4'hE, 8'h02);
		@(posedge clk_sys);
		mrst <= 1'b1;
		@(posedge clk_sys);
		mrst <= 1'b0;
		#1;
		chk("master reset", 16'h0002, 16'({irq, fdc}));
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		#1;
		chk("power reset", 16'h0100, 16'({oe, fdc}));
		stop_test();
	end
endmodule
